// ==== design/gpp_pkg.sv ====
package gpp_pkg;

  localparam int N_PINS = 12;
  localparam int N_PWM  = 8;
  localparam int N_SER  = 4;
  localparam int N_ANA  = 4;
  localparam int AW     = 8;
  localparam int DW     = 32;
  localparam int RES_W  = 13;
  localparam int PRE_W  = 8;
  localparam int ADC_W  = 12;

  // pins 3,6,7,8,9,10 carry the strong driver
  localparam logic [N_PINS-1:0] STRONG_MASK = 12'h07C8;

  // timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int PWM_MAX_HZ  = 40_000;
  localparam int PWM_FAST_HZ = 10_000;
  localparam int MIN_PROD    = CLK_HZ / PWM_MAX_HZ;
  localparam int FAST_PROD   = CLK_HZ / PWM_FAST_HZ;
  localparam logic [RES_W-1:0] RES_MIN = 13'h0064;
  localparam logic [RES_W-1:0] RES_MAX = 13'h1388;

  // register offsets
  localparam logic [AW-1:0] A_DIR     = 8'h00;
  localparam logic [AW-1:0] A_OUT     = 8'h04;
  localparam logic [AW-1:0] A_IN      = 8'h08;
  localparam logic [AW-1:0] A_DRIVE   = 8'h0C;
  localparam logic [AW-1:0] A_PULLUP  = 8'h10;
  localparam logic [AW-1:0] A_PULLDN  = 8'h14;
  localparam logic [AW-1:0] A_RISE_EN = 8'h18;
  localparam logic [AW-1:0] A_FALL_EN = 8'h1C;
  localparam logic [AW-1:0] A_ISTAT   = 8'h20;
  localparam logic [AW-1:0] A_IMASK   = 8'h24;
  localparam logic [AW-1:0] A_ANA     = 8'h28;
  localparam logic [AW-1:0] A_ADC01   = 8'h2C;
  localparam logic [AW-1:0] A_ADC23   = 8'h30;
  localparam logic [AW-1:0] A_SERMAP  = 8'h34;
  localparam logic [AW-1:0] A_PWMCFG  = 8'h38;
  localparam logic [AW-1:0] A_PWMST   = 8'h3C;
  localparam logic [AW-1:0] A_DUTY0   = 8'h40;
  localparam logic [AW-1:0] A_MAP0    = 8'h60;

  // field positions
  localparam int ANA_WIDE_BIT = 8;
  localparam int ROUTE_ERR_BIT = 12;
  localparam int CFG_PRE_LSB  = 16;
  localparam int MAP_EN_BIT   = 4;
  localparam int SER_FLD_W    = 5;
  localparam int ST_PWM_LSB   = 8;
  localparam int ST_SER_LSB   = 16;

  // reset values
  localparam logic [RES_W-1:0] RST_RES  = 13'h1388;
  localparam logic [PRE_W-1:0] RST_PRE  = 8'h00;
  localparam logic [N_PINS-1:0] RST_PIN = 12'h000;

endpackage : gpp_pkg

// ==== design/gpp_pwm_if.sv ====
interface gpp_pwm_if;
  import gpp_pkg::*;
  logic [RES_W-1:0]            res;
  logic [PRE_W-1:0]            pre;
  logic [N_PWM-1:0][RES_W-1:0] duty;
  logic [N_PWM-1:0]            wave;
  modport ctl (output res, output pre, output duty, input wave);
  modport gen (input res, input pre, input duty, output wave);
endinterface : gpp_pwm_if

// ==== design/gpp_pwm_gen.sv ====
module gpp_pwm_gen
  import gpp_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  gpp_pwm_if.gen    pw
);

  logic [PRE_W-1:0] pre_q;
  logic [RES_W-1:0] cnt_q;
  logic             tick;

  assign tick = (pre_q >= pw.pre);

  // one prescaler shared by every channel keeps a common frequency
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (tick) begin
      if (cnt_q >= pw.res - 13'h0001) begin
        cnt_q <= '0; // RULE15
      end else begin
        cnt_q <= cnt_q + 13'h0001;
      end
    end
  end

  for (genvar k = 0; k < N_PWM; k++) begin : g_ch
    logic wave_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        wave_q <= 1'b0;
      end else begin
        wave_q <= (cnt_q < pw.duty[k]); // RULE15
      end
    end
    assign pw.wave[k] = wave_q;
  end

endmodule : gpp_pwm_gen

// ==== design/gpp_top.sv ====
// Operation
// RULE1: twelve pins, each with its own input or output direction.
// RULE2: drive strength is set per pin, strong drive only on six pins.
// RULE3: each pin has a selectable pull-up and a selectable pull-down.
// RULE4: each pin can interrupt on rising, falling or any edge.
// RULE5: serial outputs may go to any strong pin and to no standard pin.
// RULE6: a PWM above ten kilohertz may only go to a strong pin.
// RULE7: a PWM at or below ten kilohertz may go to any of the twelve pins.
// RULE8: analog input exists only on pins zero to three, fixed per channel.
// RULE9: other functions may take any pin that no other function holds.
// RULE10: up to eight PWM channels run at once, each on its own pin.
// RULE11: all PWM channels share one frequency of at most forty kilohertz.
// RULE12: resolution is 100 to 5000 counts, its top bounded by frequency.
// RULE13: the converter result is eight or twelve bits wide as selected.
// RULE14: zero input reads code zero, full scale reads 255 or 4095.
// RULE15: each PWM is active for its duty count in every period.
module gpp_top
  import gpp_pkg::*;
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_resetn,
  input  wire logic [AW-1:0]           i_addr,
  input  wire logic [DW-1:0]           i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [DW-1:0]           o_rdata,
  output logic                         o_irq,
  input  wire logic [N_PINS-1:0]       i_pin,
  output logic      [N_PINS-1:0]       o_pin,
  output logic      [N_PINS-1:0]       o_pin_oe,
  output logic      [N_PINS-1:0]       o_pin_strong,
  output logic      [N_PINS-1:0]       o_pin_pullup,
  output logic      [N_PINS-1:0]       o_pin_pulldn,
  output logic      [N_ANA-1:0]        o_ana_sel,
  output logic                         o_adc_wide,
  input  wire logic [N_ANA-1:0][ADC_W-1:0] i_adc_code,
  input  wire logic [N_SER-1:0]        i_ser_out
);

  logic [N_PINS-1:0]           dir_q;
  logic [N_PINS-1:0]           out_q;
  logic [N_PINS-1:0]           drive_q;
  logic [N_PINS-1:0]           pu_q;
  logic [N_PINS-1:0]           pd_q;
  logic [N_PINS-1:0]           rise_q;
  logic [N_PINS-1:0]           fall_q;
  logic [N_PINS:0]             stat_q;
  logic [N_PINS:0]             stat_d;
  logic [N_PINS:0]             mask_q;
  logic [N_ANA-1:0]            ana_q;
  logic                        wide_q;
  logic [N_SER-1:0][SER_FLD_W-1:0] ser_map_q;
  logic [RES_W-1:0]            res_q;
  logic [PRE_W-1:0]            pre_q;
  logic [N_PWM-1:0][RES_W-1:0] duty_q;
  logic [N_PWM-1:0][MAP_EN_BIT:0] map_q;
  logic [N_PINS-1:0]           in_q;
  logic [N_PINS-1:0]           prev_q;
  logic [N_PINS-1:0]           pin_q;
  logic [N_PINS-1:0]           oe_q;
  logic [DW-1:0]               rdata_q;

  logic [N_PINS-1:0]           ana_pins;
  logic [N_PINS-1:0]           used;
  logic [N_PINS-1:0]           fact;
  logic [N_PINS-1:0]           fout;
  logic [N_SER-1:0]            ser_ok;
  logic [N_PWM-1:0]            pwm_ok;
  logic                        refused;
  logic                        fast;
  logic [N_PINS-1:0]           edge_ev;
  logic [21:0]                 prod_cur;
  logic [21:0]                 prod_new;
  logic [RES_W-1:0]            res_new;
  logic [PRE_W-1:0]            pre_new;
  logic                        cfg_ok;
  logic [21:0]                 pre_inc_new;
  logic [21:0]                 pre_inc_cur;
  logic                        wr_stat;
  logic                        wr_cfg;
  logic [N_PINS:0]             pend;

  gpp_pwm_if pwm_bus ();

  gpp_pwm_gen u_pwm (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .pw        (pwm_bus.gen)
  );

  assign pwm_bus.res  = res_q;
  assign pwm_bus.pre  = pre_q;
  assign pwm_bus.duty = duty_q;

  // frequency check: clk / ((pre+1)*res)
  assign res_new  = i_wdata[RES_W-1:0];
  assign pre_new  = i_wdata[CFG_PRE_LSB +: PRE_W];
  // widen before adding one, else a prescale of 255 wraps to a zero product
  assign pre_inc_new = {14'h0000, pre_new} + 22'h00_0001;
  assign pre_inc_cur = {14'h0000, pre_q} + 22'h00_0001;
  assign prod_new    = 22'({9'h000, res_new} * pre_inc_new);
  assign prod_cur    = 22'({9'h000, res_q} * pre_inc_cur);
  assign cfg_ok   = (res_new >= RES_MIN) && (res_new <= RES_MAX) // RULE12
                  && (prod_new >= 22'(MIN_PROD)); // RULE11
  assign fast     = (prod_cur < 22'(FAST_PROD)); // RULE6

  assign wr_stat  = i_wr && (i_addr == A_ISTAT);
  assign wr_cfg   = i_wr && (i_addr == A_PWMCFG) && cfg_ok; // RULE11 RULE12

  assign ana_pins = {{(N_PINS-N_ANA){1'b0}}, ana_q}; // RULE8

  // pin claims: analog first, then serial, then PWM by channel index
  // a refused claim raises the route error bit for as long as it stands
  always_comb begin
    used    = ana_pins;
    fact    = '0;
    fout    = '0;
    ser_ok  = '0;
    pwm_ok  = '0;
    refused = 1'b0;
    for (int s = 0; s < N_SER; s++) begin
      if (ser_map_q[s][SER_FLD_W-1]) begin
        if ((ser_map_q[s][3:0] < 4'(N_PINS))
            && STRONG_MASK[ser_map_q[s][3:0]] // RULE5
            && !used[ser_map_q[s][3:0]]) begin // RULE9
          ser_ok[s]                = 1'b1;
          used[ser_map_q[s][3:0]]  = 1'b1;
          fact[ser_map_q[s][3:0]]  = 1'b1;
          fout[ser_map_q[s][3:0]]  = i_ser_out[s];
        end else begin
          refused = 1'b1;
        end
      end
    end
    for (int k = 0; k < N_PWM; k++) begin
      if (map_q[k][MAP_EN_BIT]) begin
        if ((map_q[k][3:0] < 4'(N_PINS))
            && (!fast || STRONG_MASK[map_q[k][3:0]]) // RULE6 RULE7
            && !used[map_q[k][3:0]]) begin // RULE9 RULE10
          pwm_ok[k]             = 1'b1;
          used[map_q[k][3:0]]   = 1'b1;
          fact[map_q[k][3:0]]   = 1'b1;
          fout[map_q[k][3:0]]   = pwm_bus.wave[k];
        end else begin
          refused = 1'b1;
        end
      end
    end
  end

  // per-pin output select and edge detection
  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic sel_out;
    logic rise_ev;
    logic fall_ev;

    // a routed function overrides the plain output register
    assign sel_out    = fact[p] ? fout[p] : out_q[p];
    assign rise_ev    = in_q[p] & ~prev_q[p] & rise_q[p]; // RULE4
    assign fall_ev    = ~in_q[p] & prev_q[p] & fall_q[p]; // RULE4
    assign edge_ev[p] = rise_ev | fall_ev;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        pin_q[p] <= RST_PIN[p];
        oe_q[p]  <= RST_PIN[p];
      end else begin
        pin_q[p] <= sel_out;
        oe_q[p]  <= (fact[p] | dir_q[p]) & ~ana_pins[p]; // RULE1 RULE8
      end
    end
  end

  assign o_pin        = pin_q;
  assign o_pin_oe     = oe_q;
  assign o_pin_strong = drive_q & STRONG_MASK; // RULE2
  assign o_pin_pullup = pu_q & ~ana_pins; // RULE3
  assign o_pin_pulldn = pd_q & ~pu_q & ~ana_pins; // RULE3
  assign o_ana_sel    = ana_q;
  assign o_adc_wide   = wide_q;

  // input capture and edge events
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_q   <= '0;
      prev_q <= '0;
    end else begin
      in_q   <= i_pin & ~ana_pins;
      prev_q <= in_q;
    end
  end

  // sticky status, write one to clear, a new event wins
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~i_wdata[N_PINS:0];
    end
    stat_d = stat_d | {refused, edge_ev};
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign pend  = stat_q & mask_q;
  assign o_irq = |pend;

  // pin configuration writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_q   <= RST_PIN;
      out_q   <= RST_PIN;
      drive_q <= RST_PIN;
      pu_q    <= RST_PIN;
      pd_q    <= RST_PIN;
      rise_q  <= RST_PIN;
      fall_q  <= RST_PIN;
      mask_q  <= '0;
    end else if (i_wr) begin
      case (i_addr)
        A_DIR:     dir_q   <= i_wdata[N_PINS-1:0]; // RULE1
        A_OUT:     out_q   <= i_wdata[N_PINS-1:0];
        A_DRIVE:   drive_q <= i_wdata[N_PINS-1:0] & STRONG_MASK; // RULE2
        A_PULLUP:  pu_q    <= i_wdata[N_PINS-1:0]; // RULE3
        A_PULLDN:  pd_q    <= i_wdata[N_PINS-1:0]; // RULE3
        A_RISE_EN: rise_q  <= i_wdata[N_PINS-1:0]; // RULE4
        A_FALL_EN: fall_q  <= i_wdata[N_PINS-1:0]; // RULE4
        A_IMASK:   mask_q  <= i_wdata[N_PINS:0];
        default: ;
      endcase
    end
  end

  // analog and serial routing writes
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ana_q     <= '0;
      wide_q    <= 1'b1;
      ser_map_q <= '0;
    end else if (i_wr) begin
      case (i_addr)
        A_ANA: begin
          ana_q  <= i_wdata[N_ANA-1:0]; // RULE8
          wide_q <= i_wdata[ANA_WIDE_BIT]; // RULE13
        end
        A_SERMAP: ser_map_q <= i_wdata[N_SER*SER_FLD_W-1:0];
        default: ;
      endcase
    end
  end

  // pwm timebase: a setting out of range or above the top rate is dropped
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res_q <= RST_RES;
      pre_q <= RST_PRE;
    end else if (wr_cfg) begin
      res_q <= res_new; // RULE11 RULE12
      pre_q <= pre_new;
    end
  end

  for (genvar k = 0; k < N_PWM; k++) begin : g_pwm_reg
    logic hit_duty;
    logic hit_map;

    assign hit_duty = (i_addr == A_DUTY0 + AW'(4 * k));
    assign hit_map  = (i_addr == A_MAP0 + AW'(4 * k));

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        duty_q[k] <= '0;
        map_q[k]  <= '0;
      end else if (i_wr) begin
        if (hit_duty) begin
          duty_q[k] <= i_wdata[RES_W-1:0]; // RULE15
        end
        if (hit_map) begin
          map_q[k] <= i_wdata[MAP_EN_BIT:0]; // RULE10
        end
      end
    end
  end

  // converter code, narrow mode keeps the top eight bits
  function automatic logic [15:0] adc_view(input logic [ADC_W-1:0] c,
                                           input logic w);
    adc_view = w ? {4'h0, c} : {8'h00, c[ADC_W-1 -: 8]}; // RULE13 RULE14
  endfunction : adc_view

  // register read, data valid one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= '0;
      case (i_addr)
        A_DIR:     rdata_q[N_PINS-1:0] <= dir_q;
        A_OUT:     rdata_q[N_PINS-1:0] <= out_q;
        A_IN:      rdata_q[N_PINS-1:0] <= in_q;
        A_DRIVE:   rdata_q[N_PINS-1:0] <= drive_q;
        A_PULLUP:  rdata_q[N_PINS-1:0] <= pu_q;
        A_PULLDN:  rdata_q[N_PINS-1:0] <= pd_q;
        A_RISE_EN: rdata_q[N_PINS-1:0] <= rise_q;
        A_FALL_EN: rdata_q[N_PINS-1:0] <= fall_q;
        A_ISTAT:   rdata_q[N_PINS:0]   <= stat_q;
        A_IMASK:   rdata_q[N_PINS:0]   <= mask_q;
        A_ANA: begin
          rdata_q[N_ANA-1:0]   <= ana_q;
          rdata_q[ANA_WIDE_BIT] <= wide_q;
        end
        A_ADC01: rdata_q <= {adc_view(i_adc_code[1], wide_q),
                             adc_view(i_adc_code[0], wide_q)};
        A_ADC23: rdata_q <= {adc_view(i_adc_code[3], wide_q),
                             adc_view(i_adc_code[2], wide_q)};
        A_SERMAP: rdata_q[N_SER*SER_FLD_W-1:0] <= ser_map_q;
        A_PWMCFG: begin
          rdata_q[RES_W-1:0]             <= res_q;
          rdata_q[CFG_PRE_LSB +: PRE_W]  <= pre_q;
        end
        A_PWMST: begin
          rdata_q[0]                     <= fast;
          rdata_q[ST_PWM_LSB +: N_PWM]   <= pwm_ok;
          rdata_q[ST_SER_LSB +: N_SER]   <= ser_ok;
        end
        default: begin
          for (int k = 0; k < N_PWM; k++) begin
            if (i_addr == A_DUTY0 + AW'(4 * k)) begin
              rdata_q[RES_W-1:0] <= duty_q[k];
            end
            if (i_addr == A_MAP0 + AW'(4 * k)) begin
              rdata_q[MAP_EN_BIT:0] <= map_q[k];
            end
          end
        end
      endcase
    end
  end

  assign o_rdata = rdata_q;

endmodule : gpp_top

// ==== test/gpp_checker.sv ====
module gpp_checker
  import gpp_pkg::*;
(
  input wire logic                        i_sys_clk,
  input wire logic                        i_resetn,
  input wire logic [AW-1:0]               i_addr,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [DW-1:0]               o_rdata,
  input wire logic                        o_irq,
  input wire logic [N_PINS-1:0]           i_pin,
  input wire logic [N_PINS-1:0]           o_pin_oe,
  input wire logic [N_PINS-1:0]           o_pin_strong,
  input wire logic [N_PINS-1:0]           o_pin_pullup,
  input wire logic [N_PINS-1:0]           o_pin_pulldn,
  input wire logic [N_ANA-1:0]            o_ana_sel,
  input wire logic                        o_adc_wide,
  input wire logic [N_ANA-1:0][ADC_W-1:0] i_adc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_rd_in;
    i_rd && i_addr == A_IN && $past(i_resetn, 2);
  endsequence

  sequence s_rd_adc;
    i_rd && i_addr == A_ADC01;
  endsequence

  AST_STRONG: assert property (
    (o_pin_strong & ~STRONG_MASK) == 12'h000)
    else $error("strong drive on a standard pin");
  AST_PULL: assert property (
    (o_pin_pullup & o_pin_pulldn) == 12'h000)
    else $error("both pulls on one pin");
  AST_ANA_OE: assert property (
    (o_pin_oe[3:0] & o_ana_sel) == 4'h0)
    else $error("analog pin driven");
  AST_ANA_PULL: assert property (
    (o_pin_pullup[3:0] & o_ana_sel) == 4'h0)
    else $error("analog pin pulled up");
  AST_IN: assert property (
    s_rd_in |=> o_rdata[11:4] == $past(i_pin[11:4], 2))
    else $error("input read wrong");
  AST_IN_ANA: assert property (
    s_rd_in |=> (o_rdata[3:0] & $past(o_ana_sel)) == 4'h0)
    else $error("analog pin read as digital");
  AST_ADC: assert property (
    s_rd_adc |=> o_rdata[15:0] == ($past(o_adc_wide) ?
      {4'h0, $past(i_adc_code[0])} : {8'h00, $past(i_adc_code[0][11:4])}))
    else $error("converter code wrong");
  AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_wr))
    else $error("interrupt dropped without a write");
endmodule : gpp_checker

bind gpp_top gpp_checker i_chk (.*);

// ==== test/gpp_pins_model.sv ====
module gpp_pins_model
  import gpp_pkg::*;
(
  input  wire logic [N_PINS-1:0] i_out,
  input  wire logic [N_PINS-1:0] i_oe,
  input  wire logic [N_PINS-1:0] i_pu,
  input  wire logic [N_PINS-1:0] i_pd,
  input  wire logic [N_PINS-1:0] i_ext,
  output logic      [N_PINS-1:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven pin wins, then pull-up, then pull-down, then the outside level
  assign o_level = (i_oe & i_out)
                 | (~i_oe & i_pu)
                 | (~i_oe & ~i_pu & ~i_pd & i_ext);
endmodule : gpp_pins_model

// ==== test/gpp_top_tb_top.sv ====
module gpp_top_tb_top;
  import gpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                        i_sys_clk, i_resetn, i_wr, i_rd;
  logic                        o_irq, o_adc_wide;
  logic [AW-1:0]               i_addr;
  logic [DW-1:0]               i_wdata, o_rdata, rv;
  logic [N_PINS-1:0]           i_pin, o_pin, o_pin_oe, o_pin_strong, ext;
  logic [N_PINS-1:0]           o_pin_pullup, o_pin_pulldn;
  logic [N_ANA-1:0]            o_ana_sel;
  logic [N_ANA-1:0][ADC_W-1:0] i_adc_code;
  logic [N_SER-1:0]            i_ser_out;
  int                          err_total, n_compared, hi;

  gpp_top i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_pin_strong(o_pin_strong), .o_pin_pullup(o_pin_pullup),
    .o_pin_pulldn(o_pin_pulldn), .o_ana_sel(o_ana_sel),
    .o_adc_wide(o_adc_wide), .i_adc_code(i_adc_code), .i_ser_out(i_ser_out));
  gpp_pins_model i_pins (.i_out(o_pin), .i_oe(o_pin_oe), .i_pu(o_pin_pullup),
    .i_pd(o_pin_pulldn), .i_ext(ext), .o_level(i_pin));

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask : settle

  task automatic t_reset();
    chk(o_adc_wide, 1'b1);
    chk(o_pin_oe, 12'h000);
    rd(A_PWMCFG);
    chk(rv, 32'h0000_1388);
  endtask : t_reset

  task automatic t_dir();
    wr(A_DIR, 32'h0000_0FFF);
    wr(A_OUT, 32'h0000_0A5A);
    settle();
    chk(o_pin_oe, 12'hFFF);
    rd(A_IN);
    chk(rv, 32'h0000_0A5A);
    wr(A_DIR, 32'h0000_0000);
    wr(A_DRIVE, 32'h0000_0FFF);
    rd(A_DRIVE);
    chk(rv, 32'h0000_07C8);
    chk(o_pin_strong, 12'h7C8);
  endtask : t_dir

  task automatic t_pull();
    wr(A_PULLUP, 32'h0000_00F0);
    wr(A_PULLDN, 32'h0000_00FF);
    ext <= 12'hFFF;
    settle();
    chk(o_pin_pulldn, 12'h00F);
    chk(o_pin_pullup, 12'h0F0);
    rd(A_IN);
    chk(rv, 32'h0000_0FF0);
    wr(A_PULLUP, 32'h0000_0000);
    wr(A_PULLDN, 32'h0000_0000);
  endtask : t_pull

  task automatic t_irq();
    ext <= 12'h000;
    wr(A_RISE_EN, 32'h0000_0050);
    wr(A_FALL_EN, 32'h0000_0060);
    wr(A_IMASK, 32'h0000_0070);
    wr(A_ISTAT, 32'h0000_1FFF);
    ext <= 12'h070;
    settle();
    rd(A_ISTAT);
    chk(rv, 32'h0000_0050);
    chk(o_irq, 1'b1);
    wr(A_ISTAT, 32'h0000_0050);
    wr(A_IMASK, 32'h0000_0000);
    ext <= 12'h000;
    settle();
    rd(A_ISTAT);
    chk(rv, 32'h0000_0060);
    chk(o_irq, 1'b0);
    wr(A_ISTAT, 32'h0000_0060);
    rd(A_ISTAT);
    chk(rv, 32'h0000_0000);
  endtask : t_irq

  task automatic t_adc();
    ext <= 12'hFFF;
    wr(A_ANA, 32'h0000_010F);
    rd(A_ADC01);
    chk(rv, 32'h0FFF_0000);
    rd(A_ADC23);
    chk(rv, 32'h0123_0800);
    chk(o_ana_sel, 4'hF);
    rd(A_IN);
    chk(rv[3:0], 4'h0);
    wr(A_ANA, 32'h0000_000F);
    rd(A_ADC01);
    chk(rv, 32'h00FF_0000);
    wr(A_ANA, 32'h0000_0000);
  endtask : t_adc

  task automatic t_route();
    // ch0 on strong pin 3, ch1 on standard pin 4, ch2 on pin 3 again
    wr(A_SERMAP, 32'h0000_4E93);
    i_ser_out <= 4'hF;
    settle();
    rd(A_PWMST);
    chk(rv[19:16], 4'h1);
    chk(o_pin[3], 1'b1);
    rd(A_ISTAT);
    chk(rv[12], 1'b1);
    wr(A_SERMAP, 32'h0000_0000);
  endtask : t_route

  task automatic t_pwm();
    wr(A_PWMCFG, 32'h0009_0064);
    wr(A_PWMCFG, 32'h0009_0063);
    wr(A_PWMCFG, 32'h0000_0064);
    wr(A_PWMCFG, 32'h0000_1389);
    rd(A_PWMCFG);
    chk(rv, 32'h0009_0064);
    wr(A_DUTY0 + 8'h04, 32'h0000_001E);
    wr(A_MAP0, 32'h0000_0014);
    wr(A_MAP0 + 8'h04, 32'h0000_0016);
    settle();
    rd(A_PWMST);
    chk(rv, 32'h0000_0201);
    hi = 0;
    repeat (1000) begin
      @(posedge i_sys_clk);
      #1 hi += int'(o_pin[6] === 1'b1);
    end
    chk(hi, 300);
    wr(A_PWMCFG, 32'h0000_0271);
    wr(A_PWMCFG, 32'h0000_0270);
    rd(A_PWMCFG);
    chk(rv, 32'h0000_0271);
    wr(A_PWMCFG, 32'h00FF_0064);
    rd(A_PWMCFG);
    chk(rv, 32'h00FF_0064);
    wr(A_PWMCFG, 32'h0031_0064);
    for (int k = 0; k < N_PWM; k++) begin
      wr(A_MAP0 + 8'(4 * k), 32'h0000_0010 | 32'(k + 4));
    end
    settle();
    rd(A_PWMST);
    chk(rv, 32'h0000_FF00);
  endtask : t_pwm

  task automatic test_done();
    $display("mismatches %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (100000) @(posedge i_sys_clk);
    err_total++;
    test_done();
  end

  initial begin
    {i_wr, i_rd, i_resetn} = 3'b000;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    ext = 12'h000;
    i_ser_out = 4'h0;
    i_adc_code = {12'h123, 12'h800, 12'hFFF, 12'h000};
    err_total = 0;
    n_compared = 0;
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    settle();
    t_reset();
    t_dir();
    t_pull();
    t_irq();
    t_adc();
    t_route();
    t_pwm();
    test_done();
  end
endmodule : gpp_top_tb_top
